// File: rtl/dual_pot_cfg.svh
// Constants of the dual wiper I2C slave: bit positions, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DUAL_POT_CFG_SVH
`define DUAL_POT_CFG_SVH

`define BYTE_BITS      4'h8
`define RW_BIT         0
`define CHAN_SEL_BIT   7
`define SHDN_BIT       6
`define WIPER_MID      8'h80
`define TAP_NUM        256

`endif

// File: rtl/dual_pot_pkg.sv
// Types shared by the dual wiper I2C slave.
// Assumes the constants header sits next to it.
`default_nettype none
`include "dual_pot_cfg.svh"

package dual_pot_pkg;

    typedef logic [7:0] code_t;
    typedef logic [`TAP_NUM-1:0] tap_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h2,
        ST_INSTR     = 4'h3,
        ST_INSTR_ACK = 4'h4,
        ST_DATA      = 4'h5,
        ST_DATA_ACK  = 4'h6,
        ST_RD_BYTE   = 4'h7,
        ST_RD_ACK    = 4'h8,
        ST_WAIT_STOP = 4'h9
    } pot_state_e;

endpackage : dual_pot_pkg
`default_nettype wire

// File: rtl/dual_pot_i2c_slave.sv
// I2C slave holding two wiper codes with per-channel shutdown.
// Assumes SCL and SDA come from an external master, SDA open drain
// resolved outside from SDA_OE; SCL also clocks the bit sampler.
`default_nettype none
`include "dual_pot_cfg.svh"

module dual_pot_i2c_slave
    import dual_pot_pkg::*;
#(
    // Fixed upper address bits; value is arbitrary
    parameter logic [4:0] ADDR_FIXED = 5'h12
) (
    input  wire logic CORE_CLK,
    input  wire logic RST,
    input  wire logic CE,
    input  wire logic SCL,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    input  wire logic ADDR_SELECT_HI_PIN,
    input  wire logic ADDR_SELECT_LO_PIN,
    output var code_t WIPER_SETTING_CHANNEL_ONE,
    output var code_t WIPER_SETTING_CHANNEL_TWO,
    output var tap_t  TAP_ONE,
    output var tap_t  TAP_TWO,
    output logic      A_OPEN_ONE,
    output logic      A_OPEN_TWO
);

    // ==========================================================
    // Declarations
    logic       link_bit_r;
    logic       link_tgl_r;
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic [2:0] tgl_s_r;
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    pot_state_e state_r;
    logic [3:0] cnt_r;
    code_t      sh_r;
    code_t      tx_r;
    logic       oe_r;
    logic       rd_r;
    logic       mack_r;
    logic       sel_r;
    logic [1:0] shdn_r;
    code_t      wiper_setting_register_r [2];
    tap_t       tap_r [2];
    logic       start_det;
    logic       stop_det;
    logic       scl_fall;
    logic       bit_ev;
    logic       rx_done;
    logic       addr_match;
    code_t      rd_word;

    // ==========================================================
    // Link domain: sample SDA on each SCL rise, flag it by toggle
    always_ff @(posedge SCL or posedge RST) begin
        if (RST) begin
            link_bit_r <= 1'b0;
            link_tgl_r <= 1'b0;
        end else begin
            link_bit_r <= SDA_I;
            link_tgl_r <= ~link_tgl_r;
        end
    end

    // ==========================================================
    // Synchronisers into the core domain
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            scl_s_r  <= 3'h7;
            sda_s_r  <= 3'h7;
            tgl_s_r  <= 3'h0;
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
        end else if (CE) begin
            scl_s_r  <= {scl_s_r[1:0], SCL};
            sda_s_r  <= {sda_s_r[1:0], SDA_I};
            tgl_s_r  <= {tgl_s_r[1:0], link_tgl_r};
            pin_s1_r <= {ADDR_SELECT_HI_PIN, ADDR_SELECT_LO_PIN};
            pin_s2_r <= pin_s1_r;
        end
    end

    // Conditions seen with SCL high on both settled samples
    assign start_det = scl_s_r[1] & scl_s_r[2]
                     & sda_s_r[2] & ~sda_s_r[1];
    assign stop_det  = scl_s_r[1] & scl_s_r[2]
                     & ~sda_s_r[2] & sda_s_r[1];
    assign scl_fall  = scl_s_r[2] & ~scl_s_r[1];
    // Sampled bit stays put for a whole SCL period after the toggle
    assign bit_ev    = tgl_s_r[2] ^ tgl_s_r[1];
    assign rx_done   = scl_fall & (cnt_r == `BYTE_BITS)
                     & ~start_det & ~stop_det & ~bit_ev;

    assign addr_match = (sh_r[7:1] == {ADDR_FIXED, pin_s2_r});
    assign rd_word    = wiper_setting_register_r[sel_r];

    // ==========================================================
    // Protocol state machine
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            sh_r    <= 8'h00;
            tx_r    <= 8'h00;
            oe_r    <= 1'b0;
            rd_r    <= 1'b0;
            mack_r  <= 1'b0;
        end else if (CE) begin
            if (start_det) begin
                state_r <= ST_ADDR;
                cnt_r   <= 4'h0;
                oe_r    <= 1'b0;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                oe_r    <= 1'b0;
            end else if (bit_ev) begin
                if (state_r == ST_ADDR || state_r == ST_INSTR ||
                    state_r == ST_DATA) begin
                    sh_r  <= {sh_r[6:0], link_bit_r};
                    cnt_r <= cnt_r + 4'h1;
                end else if (state_r == ST_RD_BYTE) begin
                    cnt_r <= cnt_r + 4'h1;
                end else if (state_r == ST_RD_ACK) begin
                    mack_r <= ~link_bit_r;
                end
            end else if (scl_fall) begin
                unique case (state_r)
                    ST_IDLE: begin
                        oe_r <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (cnt_r == `BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            if (addr_match) begin
                                state_r <= ST_ADDR_ACK;
                                oe_r    <= 1'b1;
                                rd_r    <= sh_r[`RW_BIT];
                            end else begin
                                state_r <= ST_WAIT_STOP;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (rd_r) begin
                            state_r <= ST_RD_BYTE;
                            tx_r    <= rd_word;
                            oe_r    <= ~rd_word[7];
                        end else begin
                            state_r <= ST_INSTR;
                            oe_r    <= 1'b0;
                        end
                    end
                    ST_INSTR: begin
                        if (cnt_r == `BYTE_BITS) begin
                            cnt_r   <= 4'h0;
                            state_r <= ST_INSTR_ACK;
                            oe_r    <= 1'b1;
                        end
                    end
                    ST_INSTR_ACK: begin
                        state_r <= ST_DATA;
                        oe_r    <= 1'b0;
                    end
                    ST_DATA: begin
                        if (cnt_r == `BYTE_BITS) begin
                            cnt_r   <= 4'h0;
                            state_r <= ST_DATA_ACK;
                            oe_r    <= 1'b1;
                        end
                    end
                    ST_DATA_ACK: begin
                        // Bytes beyond the data byte go unanswered
                        state_r <= ST_WAIT_STOP;
                        oe_r    <= 1'b0;
                    end
                    ST_RD_BYTE: begin
                        if (cnt_r == `BYTE_BITS) begin
                            cnt_r   <= 4'h0;
                            state_r <= ST_RD_ACK;
                            oe_r    <= 1'b0;
                            mack_r  <= 1'b0;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            oe_r <= ~tx_r[6];
                        end
                    end
                    ST_RD_ACK: begin
                        if (mack_r) begin
                            state_r <= ST_RD_BYTE;
                            tx_r    <= rd_word;
                            oe_r    <= ~rd_word[7];
                        end else begin
                            state_r <= ST_WAIT_STOP;
                            oe_r    <= 1'b0;
                        end
                    end
                    ST_WAIT_STOP: begin
                        oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Channel selection, shutdown and wiper codes
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sel_r  <= 1'b0;
            shdn_r <= 2'h0;
            wiper_setting_register_r[0] <= `WIPER_MID;
            wiper_setting_register_r[1] <= `WIPER_MID;
        end else if (CE && rx_done) begin
            if (state_r == ST_INSTR) begin
                // Low six instruction bits are don't care
                sel_r <= sh_r[`CHAN_SEL_BIT];
                shdn_r[sh_r[`CHAN_SEL_BIT]] <= sh_r[`SHDN_BIT];
            end else if (state_r == ST_DATA) begin
                wiper_setting_register_r[sel_r] <= sh_r;
            end
        end
    end

    // ==========================================================
    // Tap decode: one switch per channel, B end in shutdown
    for (genvar ch = 0; ch < 2; ch++) begin : g_tap
        always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
                tap_r[ch] <= tap_t'(1) << `WIPER_MID;
            end else if (CE) begin
                if (shdn_r[ch]) begin
                    tap_r[ch] <= tap_t'(1);
                end else begin
                    tap_r[ch] <= tap_t'(1)
                              << wiper_setting_register_r[ch];
                end
            end
        end
    end

    assign SDA_O      = 1'b0;
    assign SDA_OE     = oe_r;
    assign TAP_ONE    = tap_r[0];
    assign TAP_TWO    = tap_r[1];
    assign A_OPEN_ONE = shdn_r[0];
    assign A_OPEN_TWO = shdn_r[1];
    assign WIPER_SETTING_CHANNEL_ONE = wiper_setting_register_r[0];
    assign WIPER_SETTING_CHANNEL_TWO = wiper_setting_register_r[1];

    // ==========================================================
    // Assertions
    property p_idle_quiet;
        @(posedge CORE_CLK) disable iff (RST)
        (state_r == ST_IDLE) |-> !oe_r;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("SDA driven while idle");

    property p_start_addr;
        @(posedge CORE_CLK) disable iff (RST)
        (start_det && CE) |=> (state_r == ST_ADDR) && !oe_r;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("START did not open address phase");

    property p_stop_idle;
        @(posedge CORE_CLK) disable iff (RST)
        (stop_det && !start_det && CE) |=> (state_r == ST_IDLE);
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("STOP did not end operation");

    property p_addr_miss;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && rx_done && state_r == ST_ADDR && !addr_match)
        |=> (state_r == ST_WAIT_STOP) && !oe_r;
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("Foreign address acknowledged");

    property p_addr_hit;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && rx_done && state_r == ST_ADDR && addr_match)
        |=> (state_r == ST_ADDR_ACK) && oe_r
            && (rd_r == $past(sh_r[0]));
    endproperty
    a_addr_hit: assert property (p_addr_hit)
        else $error("Address ack or direction wrong");

    property p_write_ack;
        @(posedge CORE_CLK) disable iff (RST)
        (state_r == ST_INSTR_ACK || state_r == ST_DATA_ACK) |-> oe_r;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("Write byte not acknowledged");

    property p_rd_release;
        @(posedge CORE_CLK) disable iff (RST)
        (state_r == ST_RD_ACK || state_r == ST_WAIT_STOP) |-> !oe_r;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("SDA held during master ack");

    property p_rd_nack;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && scl_fall && !start_det && !stop_det && !bit_ev
         && state_r == ST_RD_ACK && !mack_r)
        |=> (state_r == ST_WAIT_STOP);
    endproperty
    a_rd_nack: assert property (p_rd_nack)
        else $error("Transmission went on after no ack");

    property p_sel_update;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && rx_done && state_r == ST_INSTR)
        |=> (sel_r == $past(sh_r[7]));
    endproperty
    a_sel_update: assert property (p_sel_update)
        else $error("Channel select not taken");

    property p_onehot;
        @(posedge CORE_CLK) disable iff (RST)
        $onehot(tap_r[0]) && $onehot(tap_r[1]);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("Tap decode not one-hot");

    property p_shdn_tap;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && shdn_r[0]) |=> tap_r[0][0];
    endproperty
    a_shdn_tap: assert property (p_shdn_tap)
        else $error("Shutdown wiper not at B end");

    property p_restore;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && !shdn_r[0]) |=>
            (tap_r[0] == (tap_t'(1) << $past(wiper_setting_register_r[0])));
    endproperty
    a_restore: assert property (p_restore)
        else $error("Tap does not follow code");

    property p_wiper_load;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && rx_done && state_r == ST_DATA)
        |=> (rd_word == $past(sh_r));
    endproperty
    a_wiper_load: assert property (p_wiper_load)
        else $error("Data byte not stored");

    property p_shdn_keep;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && rx_done && state_r == ST_INSTR)
        |=> $stable(wiper_setting_register_r[0])
            && $stable(wiper_setting_register_r[1]);
    endproperty
    a_shdn_keep: assert property (p_shdn_keep)
        else $error("Instruction changed a wiper code");

    c_write: cover property (@(posedge CORE_CLK) disable iff (RST)
        state_r == ST_DATA_ACK);
    c_read_more: cover property (@(posedge CORE_CLK) disable iff (RST)
        state_r == ST_RD_ACK ##1 state_r == ST_RD_BYTE);
    c_miss: cover property (@(posedge CORE_CLK) disable iff (RST)
        state_r == ST_ADDR ##1 state_r == ST_WAIT_STOP);
    c_shdn: cover property (@(posedge CORE_CLK) disable iff (RST)
        $rose(shdn_r[1]));

endmodule : dual_pot_i2c_slave
`default_nettype wire

// File: bench/i2c_master_model.sv
// Behavioural I2C master for the dual wiper slave.
// Assumes the bench wires SDA as the AND of sda_drv and the slave pull-down.
`default_nettype none
module i2c_master_model (
    output var logic scl,
    output var logic sda_drv,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Start, or repeated start while a frame is open
    task automatic start_cond();
        #($urandom_range(7, 1));
        scl = 1'b0;
        #20 sda_drv = 1'b1;
        #20 scl = 1'b1;
        #40 sda_drv = 1'b0;
        #40;
    endtask : start_cond

    task automatic stop_cond();
        scl = 1'b0;
        #20 sda_drv = 1'b0;
        #20 scl = 1'b1;
        #40 sda_drv = 1'b1;
        #80;
    endtask : stop_cond

    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #20 sda_drv = b[i];
            #20 scl = 1'b1;
            #40;
        end
        scl = 1'b0;
        #20 sda_drv = 1'b1;
        #20 scl = 1'b1;
        #40 ack_n = sda_in;
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #20 sda_drv = 1'b1;
            #20 scl = 1'b1;
            #40 b[i] = sda_in;
        end
        scl = 1'b0;
        #20 sda_drv = !ack;
        #20 scl = 1'b1;
        #40;
    endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the dual wiper I2C slave.
// Assumes the master model drives the link; SDA has a pull-up.
`default_nettype none
module testbench
    import dual_pot_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [4:0] FIXED = 5'h19; // Arbitrary value

    logic core_clk, rst, ce, hi, lo, sda_oe, sda_o, a1, a2, sel;
    wire logic scl, sda_drv, sda_wire;
    code_t w1, w2;
    tap_t  tap1, tap2;
    code_t exp_code [2];
    logic  exp_sd   [2];
    int    error_cnt, num_checks;
    logic  ack;
    logic [7:0] rb;

    assign sda_wire = sda_drv & (sda_oe ? sda_o : 1'b1);

    i2c_master_model m_u (.scl(scl), .sda_drv(sda_drv), .sda_in(sda_wire));

    dual_pot_i2c_slave #(.ADDR_FIXED(FIXED)) dut_u (
        .CORE_CLK(core_clk), .RST(rst), .CE(ce), .SCL(scl),
        .SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ADDR_SELECT_HI_PIN(hi), .ADDR_SELECT_LO_PIN(lo),
        .WIPER_SETTING_CHANNEL_ONE(w1), .WIPER_SETTING_CHANNEL_TWO(w2),
        .TAP_ONE(tap1), .TAP_TWO(tap2), .A_OPEN_ONE(a1), .A_OPEN_TWO(a2)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [7:0] addr_byte(input logic rw);
        return {FIXED, hi, lo, rw};
    endfunction : addr_byte

    function automatic tap_t exp_tap(input logic c);
        return exp_sd[c] ? tap_t'(1) : tap_t'(1) << exp_code[c];
    endfunction : exp_tap

    task automatic check(input string nm, input logic [255:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wait_core(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_core

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk_outs();
        check("code one", 256'(w1), 256'(exp_code[0]));
        check("code two", 256'(w2), 256'(exp_code[1]));
        check("tap one", tap1, exp_tap(1'b0));
        check("tap two", tap2, exp_tap(1'b1));
        check("open one", 256'(a1), 256'(exp_sd[0]));
        check("open two", 256'(a2), 256'(exp_sd[1]));
    endtask : chk_outs

    task automatic do_write(input logic ch, sd, input code_t d, logic wd);
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b0), ack);
        check("address ack", 256'(ack), 256'(0));
        m_u.wr_byte({ch, sd, 6'($urandom)}, ack);
        check("instruction ack", 256'(ack), 256'(0));
        exp_sd[ch] = sd;
        sel = ch;
        if (wd) begin
            m_u.wr_byte(d, ack);
            check("data ack", 256'(ack), 256'(0));
            exp_code[ch] = d;
        end
        m_u.stop_cond();
        wait_core(8);
    endtask : do_write

    task automatic do_read();
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b1), ack);
        check("read address ack", 256'(ack), 256'(0));
        m_u.rd_byte(rb, 1'b1);
        check("read data", 256'(rb), 256'(exp_code[sel]));
        m_u.rd_byte(rb, 1'b0);
        check("read repeat", 256'(rb), 256'(exp_code[sel]));
        m_u.rd_byte(rb, 1'b0);
        check("after nack", 256'(rb), 256'(8'hff));
        m_u.stop_cond();
        wait_core(8);
    endtask : do_read

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        hi = 1'b0;
        lo = 1'b0;
        sel = 1'b0;
        exp_code = '{8'h80, 8'h80};
        exp_sd = '{1'b0, 1'b0};
        void'($urandom(69));
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        wait_core(6);
        chk_outs();
        check("idle oe", 256'(sda_oe), 256'(0));
        m_u.wr_byte(addr_byte(1'b0), ack);
        check("ack without start", 256'(ack), 256'(1));
        m_u.stop_cond();
        $display("test idle done");
        for (int i = 1; i < 8; i++) begin
            m_u.start_cond();
            m_u.wr_byte(addr_byte(1'b0) ^ (8'h01 << i), ack);
            check("foreign ack", 256'(ack), 256'(1));
            m_u.stop_cond();
        end
        $display("test foreign address done");
        for (int n = 0; n < 12; n++) begin
            {hi, lo} = 2'($urandom);
            wait_core(6);
            do_write(1'($urandom), 1'($urandom), 8'($urandom), 1'b1);
            chk_outs();
            do_read();
        end
        $display("test random traffic done");
        do_write(1'b0, 1'b0, 8'h00, 1'b1);
        do_write(1'b1, 1'b0, 8'hff, 1'b1);
        chk_outs();
        do_read();
        $display("test code limits done");
        do_write(1'b1, 1'b1, 8'h3c, 1'b1);
        chk_outs();
        do_write(1'b1, 1'b0, 8'h00, 1'b0);
        chk_outs();
        do_write(1'b0, 1'b0, 8'h00, 1'b0);
        do_read();
        $display("test shutdown done");
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b0), ack);
        m_u.wr_byte(8'h15, ack);
        m_u.wr_byte(8'h5a, ack);
        exp_code[0] = 8'h5a;
        exp_sd[0] = 1'b0;
        m_u.wr_byte(8'ha5, ack);
        check("extra byte ack", 256'(ack), 256'(1));
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b0), ack);
        m_u.wr_byte(8'h80, ack);
        sel = 1'b1;
        exp_sd[1] = 1'b0;
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b1), ack);
        check("restart ack", 256'(ack), 256'(0));
        m_u.rd_byte(rb, 1'b0);
        check("restart read", 256'(rb), 256'(exp_code[1]));
        m_u.stop_cond();
        wait_core(8);
        chk_outs();
        $display("test restart done");
        ce = 1'b0;
        m_u.start_cond();
        m_u.wr_byte(addr_byte(1'b0), ack);
        check("frozen ack", 256'(ack), 256'(1));
        m_u.stop_cond();
        wait_core(2);
        ce = 1'b1;
        wait_core(6);
        chk_outs();
        $display("test clock enable done");
        rst = 1'b1;
        wait_core(3);
        rst = 1'b0;
        exp_code = '{8'h80, 8'h80};
        exp_sd = '{1'b0, 1'b0};
        sel = 1'b0;
        wait_core(6);
        chk_outs();
        do_read();
        $display("test second reset done");
        complete_run();
    end

    initial begin
        #400000;
        error_cnt++;
        $display("watchdog expired");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
